// ### verilog/dht_regs.svh
// constants of the disk host task file: port codes, fields, reset values, counts
`ifndef DHT_REGS_SVH
`define DHT_REGS_SVH

// ============================================================
// port codes: {selected, control block, address}
`define DHT_P_DATA      5'h10
`define DHT_P_ERR       5'h11
`define DHT_P_SCNT      5'h12
`define DHT_P_SADDR     5'h13
`define DHT_P_CYLLO     5'h14
`define DHT_P_CYLHI     5'h15
`define DHT_P_UNIT      5'h16
`define DHT_P_STAT      5'h17
`define DHT_P_SHADOW    5'h1e
`define DHT_P_DIGIN     5'h1f

// ============================================================
// reset values
`define DHT_RST_ERR     8'h01
`define DHT_RST_SCNT    8'h01
`define DHT_RST_SADDR   8'h01
`define DHT_RST_CYL     11'h000
`define DHT_RST_UNIT    8'h00
`define DHT_RST_CTRL    8'h00
`define DHT_RST_STEP    4'h0

// ============================================================
// field positions
`define DHT_ST_BUSY     7
`define DHT_ST_READY    6
`define DHT_ST_WFAULT   5
`define DHT_ST_SEEKOK   4
`define DHT_ST_DREQ     3
`define DHT_ST_ERR      0
`define DHT_ER_NOID     4
`define DHT_ER_ABORT    2
`define DHT_ER_OPMASK   8'hd7
`define DHT_CT_SWRST    2

// ============================================================
// command codes (high nibble) and counts
`define DHT_C_RESTORE   4'h1
`define DHT_C_READ      4'h2
`define DHT_C_WRITE     4'h3
`define DHT_C_VERIFY    4'h4
`define DHT_C_FORMAT    4'h5
`define DHT_C_SEEK      4'h7
`define DHT_C_DIAG      4'h9
`define DHT_WORDS_LAST  8'hff

`endif

// ### verilog/dht_pkg.sv
// types of the disk host task file
`default_nettype none
package dht_pkg;
    typedef enum logic [1:0] {
        PH_DIAG = 2'b00,
        PH_IDLE = 2'b01,
        PH_CMD  = 2'b10
    } dht_phase_e;

    typedef enum logic [2:0] {
        CK_STEP  = 3'b000,
        CK_READ  = 3'b001,
        CK_WRITE = 3'b010,
        CK_OTHER = 3'b011,
        CK_DIAG  = 3'b100,
        CK_BAD   = 3'b101
    } dht_kind_e;
endpackage : dht_pkg
`default_nettype wire

// ### verilog/dht_burst_if.sv
// word strobes and sector boundary between task file and word counter
`timescale 1ns/1ps
`default_nettype none
interface dht_burst_if;
    logic wordStrobe;
    logic clear;
    logic sectorDone;
    modport counter (input wordStrobe, input clear, output sectorDone);
    modport user    (output wordStrobe, output clear, input sectorDone);
endinterface : dht_burst_if
`default_nettype wire

// ### verilog/dht_sync.sv
// two-stage synchroniser for host and drive pins
`timescale 1ns/1ps
`default_nettype none
module dht_sync #(
    parameter int W = 35
) (
    input  wire logic         core_clk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] pinIn,
    output logic      [W-1:0] pinOut
);
    logic [W-1:0] stage1;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            stage1 <= '1;
            pinOut <= '1;
        end else begin
            stage1 <= pinIn;
            pinOut <= stage1;
        end
    end
endmodule : dht_sync
`default_nettype wire

// ### verilog/dht_word_count.sv
// counts data-port words and marks each full sector burst
`timescale 1ns/1ps
`default_nettype none
`include "dht_regs.svh"
module dht_word_count (
    input  wire logic   core_clk,
    input  wire logic   arst_n,
    dht_burst_if.counter burst
);
    logic [7:0] words;

    // ============================================================
    // 256 words per sector burst
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            words            <= 8'h00;
            burst.sectorDone <= 1'b0;
        end else if (burst.clear) begin
            words            <= 8'h00;
            burst.sectorDone <= 1'b0;
        end else begin
            burst.sectorDone <= burst.wordStrobe && (words == `DHT_WORDS_LAST);
            if (burst.wordStrobe) begin
                words <= words + 8'h01;
            end
        end
    end
endmodule : dht_word_count
`default_nettype wire

// ### verilog/dht_task_file.sv
// host-visible task file of the fixed-disk controller
`timescale 1ns/1ps
`default_nettype none
`include "dht_regs.svh"
module dht_task_file (
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        taskSel_n,
    input  wire logic        ctrlSel_n,
    input  wire logic [2:0]  hostAddr,
    input  wire logic        hostRd_n,
    input  wire logic        hostWr_n,
    input  wire logic [15:0] hostDataIn,
    output logic      [15:0] hostDataOut,
    output logic             hostDataOe,
    output logic             irqReq,
    output logic             resetOut,
    input  wire logic        drvReady,
    input  wire logic        drvSeekDone,
    input  wire logic        drvWriteFault,
    input  wire logic        diskChange_n,
    input  wire logic        floppyPresent,
    input  wire logic [6:0]  testIn,
    output logic             cmdStart,
    output logic      [7:0]  cmdCode,
    output logic      [3:0]  stepRate,
    output logic      [7:0]  sectorCount,
    output logic      [7:0]  sectorAddr,
    output logic      [10:0] cylinder,
    output logic      [7:0]  unitHead,
    input  wire logic        bufReady,
    input  wire logic        secDone,
    input  wire logic [7:0]  secAddrIn,
    input  wire logic [10:0] cylIn,
    input  wire logic        cmdDone,
    input  wire logic [7:0]  cmdErr,
    input  wire logic        diagDone,
    input  wire logic [7:0]  diagCode,
    output logic      [15:0] dataWord,
    output logic             dataWordValid,
    input  wire logic [15:0] readWord,
    output logic             readWordTaken
);
    // ============================================================
    // pin synchronisation
    logic [34:0] pinSync;
    logic        sTask_n;
    logic        sCtrl_n;
    logic [2:0]  sAddr;
    logic        sRd_n;
    logic        sWr_n;
    logic [15:0] sData;
    logic        sReady;
    logic        sSeekOk;
    logic        sWFault;
    logic        sChange_n;
    logic        sFloppy;
    logic [6:0]  sTest;

    dht_sync #(.W(35)) pinSyncer (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .pinIn    ({taskSel_n, ctrlSel_n, hostAddr, hostRd_n, hostWr_n, hostDataIn,
                    drvReady, drvSeekDone, drvWriteFault, diskChange_n, floppyPresent,
                    testIn}),
        .pinOut   (pinSync)
    );

    assign {sTask_n, sCtrl_n, sAddr, sRd_n, sWr_n, sData,
            sReady, sSeekOk, sWFault, sChange_n, sFloppy, sTest} = pinSync;

    // ============================================================
    // decoding and strobe edges
    function automatic logic [4:0] portSel(input logic t_n, input logic c_n,
                                           input logic [2:0] a);
        portSel = (!t_n) ? {2'b10, a} : (!c_n) ? {2'b11, a} : 5'h00;
    endfunction : portSel

    function automatic dht_pkg::dht_kind_e kindOf(input logic [7:0] code);
        unique case (code[7:4])
            `DHT_C_RESTORE, `DHT_C_SEEK: kindOf = dht_pkg::CK_STEP;
            `DHT_C_READ:                 kindOf = dht_pkg::CK_READ;
            `DHT_C_WRITE, `DHT_C_FORMAT: kindOf = dht_pkg::CK_WRITE;
            `DHT_C_VERIFY:               kindOf = dht_pkg::CK_OTHER;
            `DHT_C_DIAG:                 kindOf = dht_pkg::CK_DIAG;
            default:                     kindOf = dht_pkg::CK_BAD;
        endcase
    endfunction : kindOf

    logic rdPrev_n;
    logic wrPrev_n;
    logic rdStart;
    logic wrEnd;
    logic [4:0] selNow;

    assign selNow  = portSel(sTask_n, sCtrl_n, sAddr);
    assign rdStart = !sRd_n && rdPrev_n;
    assign wrEnd   = sWr_n && !wrPrev_n;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdPrev_n <= 1'b1;
            wrPrev_n <= 1'b1;
        end else begin
            rdPrev_n <= sRd_n;
            wrPrev_n <= sWr_n;
        end
    end

    // ============================================================
    // control register and programmed reset
    logic [7:0] ctrlReg;
    logic       swRst;

    assign swRst = ctrlReg[`DHT_CT_SWRST];

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrlReg  <= `DHT_RST_CTRL;
            resetOut <= 1'b1;
        end else begin
            resetOut <= swRst;
            if (wrEnd && selNow == `DHT_P_SHADOW) begin
                ctrlReg <= sData[7:0];
            end
        end
    end

    // ============================================================
    // command launch and phase
    dht_pkg::dht_phase_e phase;
    dht_pkg::dht_kind_e  kind;
    logic                cmdWrite;
    logic                dataReq;
    logic                statErr;
    logic [7:0]          errReg;
    logic                badStart;
    dht_pkg::dht_kind_e  newKind;

    assign cmdWrite = wrEnd && selNow == `DHT_P_STAT;
    assign newKind  = kindOf(sData[7:0]);
    // reads, writes other than format, and verifies need a real start sector
    assign badStart = (newKind == dht_pkg::CK_READ || newKind == dht_pkg::CK_WRITE
                       || newKind == dht_pkg::CK_OTHER) && sectorAddr == 8'h00
                      && sData[7:4] != `DHT_C_FORMAT;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            phase    <= dht_pkg::PH_DIAG;
            kind     <= dht_pkg::CK_OTHER;
            cmdStart <= 1'b0;
            cmdCode  <= 8'h00;
        end else if (swRst) begin
            phase    <= dht_pkg::PH_DIAG;
            kind     <= dht_pkg::CK_OTHER;
            cmdStart <= 1'b0;
        end else begin
            cmdStart <= 1'b0;
            unique case (phase)
                dht_pkg::PH_DIAG: begin
                    if (diagDone) begin
                        phase <= dht_pkg::PH_IDLE;
                    end
                end
                dht_pkg::PH_IDLE: begin
                    if (cmdWrite && !badStart && newKind != dht_pkg::CK_BAD) begin
                        cmdCode  <= sData[7:0];
                        kind     <= newKind;
                        cmdStart <= 1'b1;
                        phase    <= (newKind == dht_pkg::CK_DIAG) ? dht_pkg::PH_DIAG
                                                                  : dht_pkg::PH_CMD;
                    end
                end
                dht_pkg::PH_CMD: begin
                    if (cmdDone) begin
                        phase <= dht_pkg::PH_IDLE;
                    end
                end
                default: begin
                    phase <= dht_pkg::PH_IDLE;
                end
            endcase
        end
    end

    // ============================================================
    // step rate kept across commands
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            stepRate <= `DHT_RST_STEP;
        end else if (cmdWrite && phase == dht_pkg::PH_IDLE && newKind == dht_pkg::CK_STEP) begin
            stepRate <= sData[3:0];
        end
    end

    // ============================================================
    // error register and status error bit
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            errReg  <= `DHT_RST_ERR;
            statErr <= 1'b0;
        end else if (swRst) begin
            errReg  <= `DHT_RST_ERR;
            statErr <= 1'b0;
        end else if (phase == dht_pkg::PH_DIAG && diagDone) begin
            errReg  <= diagCode;
            statErr <= diagCode != `DHT_RST_ERR;
        end else if (phase == dht_pkg::PH_CMD && cmdDone) begin
            errReg  <= cmdErr & `DHT_ER_OPMASK;
            statErr <= |(cmdErr & `DHT_ER_OPMASK);
        end else if (cmdWrite && phase == dht_pkg::PH_IDLE) begin
            // held until the command ends, or for a rejected command until the next command write
            errReg  <= badStart ? (8'h01 << `DHT_ER_NOID)
                     : (newKind == dht_pkg::CK_BAD) ? (8'h01 << `DHT_ER_ABORT)
                     : 8'h00;
            statErr <= badStart || newKind == dht_pkg::CK_BAD;
        end
    end

    // ============================================================
    // parameter registers
    logic cntMoved;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cntMoved    <= 1'b0;
            sectorCount <= `DHT_RST_SCNT;
            sectorAddr  <= `DHT_RST_SADDR;
            cylinder    <= `DHT_RST_CYL;
            unitHead    <= `DHT_RST_UNIT;
        end else if (swRst) begin
            sectorCount <= `DHT_RST_SCNT;
            sectorAddr  <= `DHT_RST_SADDR;
            cylinder    <= `DHT_RST_CYL;
            unitHead    <= `DHT_RST_UNIT;
        end else if (phase == dht_pkg::PH_CMD && secDone) begin
            // zero at the start stands for 256; once a sector moved, zero is the end
            cntMoved <= 1'b1;
            if (sectorCount != 8'h00 || !cntMoved) begin
                sectorCount <= sectorCount - 8'h01;
            end
            sectorAddr <= secAddrIn;
            cylinder   <= cylIn;
        end else if (wrEnd && phase != dht_pkg::PH_CMD) begin
            unique case (selNow)
                `DHT_P_SCNT:  sectorCount     <= sData[7:0];
                `DHT_P_SADDR: sectorAddr      <= sData[7:0];
                `DHT_P_CYLLO: cylinder[7:0]   <= sData[7:0];
                `DHT_P_CYLHI: cylinder[10:8]  <= sData[2:0];
                `DHT_P_UNIT:  unitHead        <= sData[7:0];
                default:      cntMoved        <= 1'b0;  // command write rearms
            endcase
        end
    end

    // ============================================================
    // data request and sector bursts
    dht_burst_if burst ();

    dht_word_count wordCounter (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .burst    (burst)
    );

    logic dataSel;

    assign dataSel          = selNow == `DHT_P_DATA && dataReq;
    assign burst.wordStrobe = dataSel && ((kind == dht_pkg::CK_READ && rdStart)
                              || (kind == dht_pkg::CK_WRITE && wrEnd));
    assign burst.clear      = swRst || cmdStart;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            dataReq <= 1'b0;
        end else if (swRst || phase != dht_pkg::PH_CMD || cmdDone) begin
            dataReq <= 1'b0;
        end else if (bufReady && (kind == dht_pkg::CK_READ || kind == dht_pkg::CK_WRITE)) begin
            dataReq <= 1'b1;
        end else if (burst.sectorDone) begin
            dataReq <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            dataWord      <= 16'h0000;
            dataWordValid <= 1'b0;
            readWordTaken <= 1'b0;
        end else begin
            dataWordValid <= burst.wordStrobe && kind == dht_pkg::CK_WRITE;
            readWordTaken <= burst.wordStrobe && kind == dht_pkg::CK_READ;
            if (burst.wordStrobe && kind == dht_pkg::CK_WRITE) begin
                dataWord <= sData;
            end
        end
    end

    // ============================================================
    // interrupt request
    logic irqSet;

    // a sector ready for reading, a command end that failed or was not a read, a rejected command write
    assign irqSet = (phase == dht_pkg::PH_CMD && bufReady && kind == dht_pkg::CK_READ)
                 || (phase == dht_pkg::PH_CMD && cmdDone
                     && (kind != dht_pkg::CK_READ || |(cmdErr & `DHT_ER_OPMASK)))
                 || (cmdWrite && phase == dht_pkg::PH_IDLE
                     && (badStart || newKind == dht_pkg::CK_BAD));

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irqReq <= 1'b0;
        end else if (swRst) begin
            irqReq <= 1'b0;
        end else if (irqSet) begin
            // a new event outweighs a clearing read in the same cycle
            irqReq <= 1'b1;
        end else if (cmdWrite || (rdStart && selNow == `DHT_P_STAT)) begin
            irqReq <= 1'b0;
        end
    end

    // ============================================================
    // host read port
    logic       busyNow;
    logic [7:0] statusNow;
    logic [7:0] digitalNow;

    assign busyNow = phase != dht_pkg::PH_IDLE || swRst;

    // while busy only the busy and data request bits carry meaning
    always_comb begin
        statusNow                 = 8'h00;
        statusNow[`DHT_ST_BUSY]   = busyNow;
        statusNow[`DHT_ST_DREQ]   = dataReq;
        statusNow[`DHT_ST_READY]  = !busyNow && sReady;
        statusNow[`DHT_ST_WFAULT] = !busyNow && sWFault;
        statusNow[`DHT_ST_SEEKOK] = !busyNow && sSeekOk;
        statusNow[`DHT_ST_ERR]    = !busyNow && statErr;
    end

    // bit 7 belongs to the floppy side and reads zero without it
    assign digitalNow = {sFloppy && !sChange_n, sTest};

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            hostDataOut <= 16'h0000;
            hostDataOe  <= 1'b0;
        end else if (rdStart) begin
            hostDataOe <= selNow != 5'h00;
            unique case (selNow)
                `DHT_P_DATA:   hostDataOut <= dataSel ? readWord : 16'h0000;
                `DHT_P_ERR:    hostDataOut <= {8'h00, errReg};
                `DHT_P_SCNT:   hostDataOut <= {8'h00, sectorCount};
                `DHT_P_SADDR:  hostDataOut <= {8'h00, sectorAddr};
                `DHT_P_CYLLO:  hostDataOut <= {8'h00, cylinder[7:0]};
                `DHT_P_CYLHI:  hostDataOut <= {13'h0000, cylinder[10:8]};
                `DHT_P_UNIT:   hostDataOut <= {8'h00, unitHead};
                `DHT_P_STAT:   hostDataOut <= {8'h00, statusNow};
                `DHT_P_SHADOW: hostDataOut <= {8'h00, statusNow};
                `DHT_P_DIGIN:  hostDataOut <= {8'h00, digitalNow};
                default:       hostDataOut <= 16'h0000;
            endcase
        end else if (sRd_n) begin
            hostDataOe <= 1'b0;
        end
    end
endmodule : dht_task_file
`default_nettype wire

// ### bench/dht_task_file_properties.sv
// port assertions of the disk host task file
`timescale 1ns/1ps
`default_nettype none
`include "dht_regs.svh"
module dht_task_file_chk (
    input wire logic        core_clk,
    input wire logic        arst_n,
    input wire logic        taskSel_n,
    input wire logic        ctrlSel_n,
    input wire logic        irqReq,
    input wire logic        cmdStart,
    input wire logic [7:0]  cmdCode,
    input wire logic [7:0]  sectorCount,
    input wire logic [7:0]  sectorAddr,
    input wire logic [10:0] cylinder,
    input wire logic [7:0]  unitHead,
    input wire logic        bufReady,
    input wire logic        secDone,
    input wire logic [7:0]  secAddrIn,
    input wire logic [10:0] cylIn,
    input wire logic        cmdDone,
    input wire logic [7:0]  cmdErr,
    input wire logic        dataWordValid
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // ==========
    // no select for four edges: the synchronised pins cannot take an access
    sequence busQuiet;
        (taskSel_n && ctrlSel_n) [*4];
    endsequence
    AST_RESET_VALUES: assert property ($rose(arst_n) |-> sectorCount == 8'h01
        && sectorAddr == 8'h01 && cylinder == 11'h000 && unitHead == 8'h00)
        else $error("task file not at reset values");
    AST_CMD_PULSE: assert property (cmdStart |=> !cmdStart)
        else $error("command start longer than one cycle");
    AST_CMD_CLEARS_IRQ: assert property (cmdStart |-> !irqReq)
        else $error("interrupt pending at command start");
    AST_IRQ_LATCH: assert property (busQuiet ##0 irqReq |=> irqReq)
        else $error("interrupt dropped without a host access");
    AST_ERR_IRQ: assert property (cmdDone && (cmdErr & `DHT_ER_OPMASK) != 8'h00 |=> irqReq)
        else $error("failed command raised no interrupt");
    AST_BUF_IRQ: assert property (bufReady && cmdCode[7:4] == `DHT_C_READ |=> irqReq)
        else $error("buffered read sector raised no interrupt");
    AST_COUNT_DEC: assert property (secDone && sectorCount != 8'h00
        |=> sectorCount == $past(sectorCount) - 8'h01) else $error("count not decremented");
    AST_ADDR_TRACK: assert property (secDone |=> sectorAddr == $past(secAddrIn)
        && cylinder == $past(cylIn)) else $error("address not tracking last sector");
    AST_WORD_PULSE: assert property (dataWordValid |=> !dataWordValid)
        else $error("data word strobe longer than one cycle");
endmodule : dht_task_file_chk
`default_nettype wire

// ### bench/dht_host_model.sv
// host processor model: port reads and writes on the task file pins
`timescale 1ns/1ps
`default_nettype none
module dht_host_model (
    input  wire logic        core_clk,
    output logic             taskSel_n,
    output logic             ctrlSel_n,
    output logic      [2:0]  hostAddr,
    output logic             hostRd_n,
    output logic             hostWr_n,
    output logic      [15:0] hostDataIn,
    input  wire logic [15:0] hostDataOut,
    input  wire logic        hostDataOe
);
    initial begin
        {taskSel_n, ctrlSel_n, hostRd_n, hostWr_n} = 4'hf;
        hostAddr = 3'h0;
        hostDataIn = 16'h0000;
    end
    // ==========
    // port code is {selected, control block, address}
    task automatic sel(input logic [4:0] p);
        taskSel_n <= !(p[4] && !p[3]);
        ctrlSel_n <= !(p[4] && p[3]);
        hostAddr <= p[2:0];
    endtask : sel
    // strobes held four edges each way, two more than the two-stage synchroniser needs
    task automatic wr(input logic [4:0] p, input logic [15:0] d);
        @(posedge core_clk);
        sel(p);
        hostDataIn <= d;
        hostWr_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        hostWr_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        sel(5'h00);
        hostDataIn <= ~d; // released bus shows no stale value
    endtask : wr
    task automatic rd(input logic [4:0] p, output logic [15:0] d);
        int n;
        d = 'x;
        @(posedge core_clk);
        sel(p);
        hostRd_n <= 1'b0;
        for (n = 0; n < 12 && hostDataOe !== 1'b1; n++) @(negedge core_clk);
        if (hostDataOe === 1'b1) d = hostDataOut;
        @(posedge core_clk);
        hostRd_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        sel(5'h00);
    endtask : rd
endmodule : dht_host_model
`default_nettype wire

// ### bench/dht_task_file_tb.sv
// self-checking testbench of the disk host task file
`timescale 1ns/1ps
`default_nettype none
`include "dht_regs.svh"
module dht_task_file_tb;
    logic        core_clk, arst_n, taskSel_n, ctrlSel_n, hostRd_n, hostWr_n, hostDataOe;
    logic        irqReq, resetOut, drvReady, drvSeekDone, cmdStart, bufReady, secDone;
    logic        cmdDone, diagDone, dataWordValid, readWordTaken;
    logic [2:0]  hostAddr;
    logic [3:0]  stepRate;
    logic [7:0]  cmdCode, sectorCount, sectorAddr, unitHead, secAddrIn, cmdErr, diagCode;
    logic [10:0] cylinder, cylIn;
    logic [15:0] hostDataIn, hostDataOut, dataWord, readWord;
    int          n_errors, n_checks;
    dht_task_file dht_task_file_i (.core_clk, .arst_n, .taskSel_n, .ctrlSel_n, .hostAddr,
        .hostRd_n, .hostWr_n, .hostDataIn, .hostDataOut, .hostDataOe, .irqReq, .resetOut,
        .drvReady, .drvSeekDone, .drvWriteFault(1'b0), .diskChange_n(1'b1),
        .floppyPresent(1'b1), .testIn(7'h00), .cmdStart, .cmdCode, .stepRate, .sectorCount,
        .sectorAddr, .cylinder, .unitHead, .bufReady, .secDone, .secAddrIn, .cylIn, .cmdDone,
        .cmdErr, .diagDone, .diagCode, .dataWord, .dataWordValid, .readWord, .readWordTaken);
    dht_host_model host_i (.core_clk, .taskSel_n, .ctrlSel_n, .hostAddr, .hostRd_n,
        .hostWr_n, .hostDataIn, .hostDataOut, .hostDataOe);
    always #2 core_clk = ~core_clk;
    // ==========
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic rdc(input logic [4:0] p, input logic [7:0] e);
        logic [15:0] d;
        host_i.rd(p, d);
        chk(d[7:0], e);
    endtask : rdc
    // back end event: 0 buffer ready, 1 sector done, 2 command done, 3 self test done
    task automatic beat(input int k, input logic [7:0] a, input logic [10:0] c);
        @(posedge core_clk);
        case (k)
            0: bufReady <= 1'b1;
            1: {secDone, secAddrIn, cylIn} <= {1'b1, a, c};
            2: {cmdDone, cmdErr} <= {1'b1, a};
            default: {diagDone, diagCode} <= {1'b1, a};
        endcase
        @(posedge core_clk);
        {bufReady, secDone, cmdDone, diagDone} <= 4'h0;
        @(negedge core_clk);
    endtask : beat
    // polls status only while busy
    task automatic idle();
        logic [15:0] d;
        int n;
        d = 16'hffff;
        for (n = 0; n < 40 && d[7] !== 1'b0; n++) host_i.rd(`DHT_P_STAT, d);
        chk({7'h0, d[7]}, 8'h00);
    endtask : idle
    task automatic finish_test();
        if (n_errors == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : finish_test
    initial begin
        repeat (60000) @(posedge core_clk);
        n_errors++;
        finish_test();
    end
    initial begin
        int i;
        {n_errors, n_checks, core_clk, arst_n, bufReady, secDone, cmdDone, diagDone} = '0;
        {drvReady, drvSeekDone, secAddrIn, cylIn, cmdErr, diagCode} = {2'b11, 35'h0};
        readWord = 16'h5aa5;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        beat(3, 8'h03, 11'h000);
        idle();
        rdc(`DHT_P_ERR, 8'h03);
        rdc(`DHT_P_SCNT, 8'h01);
        rdc(`DHT_P_SADDR, 8'h01);
        rdc(`DHT_P_CYLHI, 8'h00);
        rdc(`DHT_P_UNIT, 8'h00);
        host_i.wr(`DHT_P_SHADOW, 16'h0004);
        rdc(`DHT_P_STAT, 8'h80);
        chk({7'h0, resetOut}, 8'h01);
        host_i.wr(`DHT_P_SHADOW, 16'h0000);
        beat(3, 8'h01, 11'h000);
        idle();
        rdc(`DHT_P_ERR, 8'h01);
        host_i.wr(`DHT_P_CYLHI, 16'h00ff);
        rdc(`DHT_P_CYLHI, 8'h07);
        host_i.wr(`DHT_P_STAT, 16'h007a);
        chk({4'h0, stepRate}, 8'h0a);
        beat(2, 8'h00, 11'h000);
        rdc(`DHT_P_SHADOW, 8'h50);
        chk({7'h0, irqReq}, 8'h01);
        rdc(`DHT_P_STAT, 8'h50);
        chk({7'h0, irqReq}, 8'h00);
        host_i.wr(`DHT_P_STAT, 16'h0013);
        beat(2, 8'h00, 11'h000);
        host_i.wr(`DHT_P_SCNT, 16'h0002);
        host_i.wr(`DHT_P_SADDR, 16'h0005);
        host_i.wr(`DHT_P_STAT, 16'h0020);
        beat(0, 8'h00, 11'h000);
        chk({7'h0, irqReq}, 8'h01);
        rdc(`DHT_P_STAT, 8'h88);
        for (i = 0; i < 256; i++) rdc(`DHT_P_DATA, 8'ha5);
        repeat (3) beat(1, 8'h05, 11'h123);
        rdc(`DHT_P_STAT, 8'h80);
        beat(2, 8'h00, 11'h000);
        idle();
        rdc(`DHT_P_SCNT, 8'h00);
        rdc(`DHT_P_SADDR, 8'h05);
        rdc(`DHT_P_CYLLO, 8'h23);
        rdc(`DHT_P_CYLHI, 8'h01);
        chk({4'h0, stepRate}, 8'h03);
        host_i.wr(`DHT_P_SCNT, 16'h0000);
        host_i.wr(`DHT_P_STAT, 16'h0030);
        beat(0, 8'h00, 11'h000);
        rdc(`DHT_P_STAT, 8'h88);
        for (i = 0; i < 256; i++) host_i.wr(`DHT_P_DATA, 16'(i));
        chk(dataWord[7:0], 8'hff);
        beat(1, 8'h05, 11'h123);
        beat(2, 8'h40, 11'h000);
        chk({7'h0, irqReq}, 8'h01);
        rdc(`DHT_P_STAT, 8'h51);
        rdc(`DHT_P_ERR, 8'h40);
        rdc(`DHT_P_ERR, 8'h40);
        rdc(`DHT_P_SCNT, 8'hff);
        host_i.wr(`DHT_P_SADDR, 16'h0000);
        host_i.wr(`DHT_P_STAT, 16'h0020);
        idle();
        rdc(`DHT_P_ERR, 8'h10);
        host_i.wr(`DHT_P_STAT, 16'h00f0);
        idle();
        rdc(`DHT_P_ERR, 8'h04);
        host_i.wr(`DHT_P_SCNT, 16'h0011);
        host_i.wr(`DHT_P_STAT, 16'h0050);
        beat(0, 8'h00, 11'h000);
        rdc(`DHT_P_STAT, 8'h88);
        beat(2, 8'h00, 11'h000);
        idle();
        rdc(`DHT_P_ERR, 8'h00);
        finish_test();
    end
endmodule : dht_task_file_tb
bind dht_task_file dht_task_file_chk dht_task_file_chk_i (.core_clk, .arst_n, .taskSel_n,
    .ctrlSel_n, .irqReq, .cmdStart, .cmdCode, .sectorCount, .sectorAddr, .cylinder,
    .unitHead, .bufReady, .secDone, .secAddrIn, .cylIn, .cmdDone, .cmdErr, .dataWordValid);
`default_nettype wire
